// >>> common/flags_pkg.sv
/*
  Shared constants for the flag register, option register and ALU.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flags_pkg;
  // ==========================================================
  // register map
  localparam logic [6:0] FLAGS_OFFSET = 7'h03;
  localparam logic [6:0] OPTION_OFFSET = 7'h01;
  // ==========================================================
  // flag register field positions
  localparam int BIT_CARRY = 0;
  localparam int BIT_DIGIT = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_PDOWN = 3;
  localparam int BIT_TOUT = 4;
  localparam int BIT_BANK_LOW = 5;
  localparam int BIT_BANK_HIGH = 6;
  localparam int BIT_IND_BANK = 7;
  // ==========================================================
  // option register field positions
  localparam int OPT_PULLUP_DIS = 7;
  localparam int OPT_INT_EDGE = 6;
  localparam int OPT_CLK_SRC = 5;
  localparam int OPT_SRC_EDGE = 4;
  localparam int OPT_PRESC_WDOG = 3;
  localparam int OPT_RATE_MSB = 2;
  // ==========================================================
  // reset values
  localparam logic [7:0] FLAGS_RESET = 8'h18;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  // ==========================================================
  // ALU operations
  typedef enum logic [3:0] {
    OP_PASS = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
    OP_IOR = 4'h4, OP_XOR = 4'h5, OP_COM = 4'h6, OP_INC = 4'h7,
    OP_DEC = 4'h8, OP_RLF = 4'h9, OP_RRF = 4'hA, OP_SWAP = 4'hB,
    OP_CLR = 4'hC, OP_BCLR = 4'hD, OP_BSET = 4'hE
  } alu_op_type;
endpackage : flags_pkg

// >>> core/alu_unit.sv
/*
  Combinational 8-bit ALU with zero, digit-carry and carry outcomes.
  Assumes the caller registers the result and decides which flags land.
*/
`timescale 1ns/10ps
`default_nettype none
module alu_unit (
  input wire flags_pkg::alu_op_type op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic [2:0] bit_sel,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic zero_out,
  output logic digit_out,
  output logic carry_out,
  output logic affects_z,
  output logic affects_dc_c
);
  // ==========================================================
  // adder with carry taps
  function automatic logic [9:0] add_taps(input logic [7:0] a, input logic [7:0] b);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full = {1'b0, a} + {1'b0, b};
    add_taps = {lo[4], full};
  endfunction : add_taps

  logic [9:0] sum;
  logic [7:0] neg_b;
  logic [7:0] bit_mask;

  // subtraction adds the two's complement, so carry means no borrow
  assign neg_b = 8'(~opa + 8'h01);
  assign bit_mask = 8'h01 << bit_sel;

  // operation select
  always_comb begin
    sum = 10'h000;
    result = opb;
    carry_out = carry_in;
    digit_out = 1'b0;
    affects_z = 1'b1;
    affects_dc_c = 1'b0;
    unique case (op)
      flags_pkg::OP_ADD: begin
        sum = add_taps(opa, opb);
        result = sum[7:0];
        carry_out = sum[8];
        digit_out = sum[9];
        affects_dc_c = 1'b1;
      end
      flags_pkg::OP_SUB: begin
        // result = opb - opa; carry/digit are inverted borrows
        sum = add_taps(opb, neg_b);
        result = sum[7:0];
        carry_out = sum[8] | (opa == 8'h00);
        digit_out = sum[9] | (opa[3:0] == 4'h0);
        affects_dc_c = 1'b1;
      end
      flags_pkg::OP_AND: result = opa & opb;
      flags_pkg::OP_IOR: result = opa | opb;
      flags_pkg::OP_XOR: result = opa ^ opb;
      flags_pkg::OP_COM: result = ~opb;
      flags_pkg::OP_INC: result = 8'(opb + 8'h01);
      flags_pkg::OP_DEC: result = 8'(opb - 8'h01);
      flags_pkg::OP_CLR: result = 8'h00;
      flags_pkg::OP_RLF: begin
        result = {opb[6:0], carry_in};
        carry_out = opb[7];
        affects_z = 1'b0;
      end
      flags_pkg::OP_RRF: begin
        result = {carry_in, opb[7:1]};
        carry_out = opb[0];
        affects_z = 1'b0;
      end
      flags_pkg::OP_SWAP: begin
        result = {opb[3:0], opb[7:4]};
        affects_z = 1'b0;
      end
      flags_pkg::OP_BCLR: begin
        result = opb & ~bit_mask;
        affects_z = 1'b0;
      end
      flags_pkg::OP_BSET: begin
        result = opb | bit_mask;
        affects_z = 1'b0;
      end
      flags_pkg::OP_PASS: affects_z = 1'b0;
      default: affects_z = 1'b0; // unused encoding
    endcase
  end

  assign zero_out = (result == 8'h00);
endmodule : alu_unit
`default_nettype wire

// >>> core/option_ctrl.sv
/*
  Option register storage and decode of the shared prescaler.
  Assumes writes arrive as a single-cycle strobe on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module option_ctrl (
  input wire logic clock,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] option_r,
  output logic [7:0] timer_zero_ratio_log2,
  output logic [7:0] watchdog_timer_ratio_log2,
  output logic portb_pullup_en,
  output logic ext_int_rising,
  output logic timer_zero_ext_clk,
  output logic timer_zero_falling
);
  // ==========================================================
  // storage: fully readable and writable
  always_ff @(posedge clock) begin
    if (srst) begin
      option_r <= flags_pkg::OPTION_RESET;
    end else if (wr_en) begin
      option_r <= wr_data;
    end
  end

  // ==========================================================
  // one prescaler, assigned to only one user; the other runs 1:1
  always_comb begin
    if (option_r[flags_pkg::OPT_PRESC_WDOG]) begin
      timer_zero_ratio_log2 = 8'h00;
      watchdog_timer_ratio_log2 = {5'h00, option_r[flags_pkg::OPT_RATE_MSB:0]};
    end else begin
      timer_zero_ratio_log2 = 8'(option_r[flags_pkg::OPT_RATE_MSB:0] + 4'h1);
      watchdog_timer_ratio_log2 = 8'h00;
    end
  end

  // pin and timer controls
  assign portb_pullup_en = ~option_r[flags_pkg::OPT_PULLUP_DIS];
  assign ext_int_rising = option_r[flags_pkg::OPT_INT_EDGE];
  assign timer_zero_ext_clk = option_r[flags_pkg::OPT_CLK_SRC];
  assign timer_zero_falling = option_r[flags_pkg::OPT_SRC_EDGE];
endmodule : option_ctrl
`default_nettype wire

// >>> core/alu_status_and_option_flags.sv
/*
  Flag register with ALU, bank select and reset-cause bits, plus the option
  register. Assumes one instruction per clock presented by the core's
  decoder: an op, its operands, a destination offset and a write strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module alu_status_and_option_flags (
  input wire logic clock,
  input wire logic srst,
  input wire flags_pkg::alu_op_type op,
  input wire logic [7:0] work_reg,
  input wire logic [7:0] file_operand,
  input wire logic [2:0] bit_sel,
  input wire logic [6:0] file_addr,
  input wire logic dest_is_file,
  input wire logic exec,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  output logic [7:0] result_r,
  output logic [7:0] flags_r,
  output logic [7:0] option_rd,
  output logic [8:0] direct_addr,
  output logic [7:0] timer_zero_ratio_log2,
  output logic [7:0] watchdog_timer_ratio_log2,
  output logic portb_pullup_en,
  output logic ext_int_rising,
  output logic timer_zero_ext_clk,
  output logic timer_zero_falling
);
  // ==========================================================
  // ALU
  logic [7:0] alu_result;
  logic zero_out;
  logic digit_out;
  logic carry_out;
  logic affects_z;
  logic affects_dc_c;
  logic [7:0] operand_b;
  logic to_flags;
  logic to_option;
  logic [7:0] flags_nxt;
  logic carry_hit;
  logic arith_hit;

  // the flag register reads back like any other file
  assign operand_b = (file_addr == flags_pkg::FLAGS_OFFSET) ? flags_r : file_operand;

  alu_unit u_alu (
    .op(op),
    .opa(work_reg),
    .opb(operand_b),
    .bit_sel(bit_sel),
    .carry_in(flags_r[flags_pkg::BIT_CARRY]),
    .result(alu_result),
    .zero_out(zero_out),
    .digit_out(digit_out),
    .carry_out(carry_out),
    .affects_z(affects_z),
    .affects_dc_c(affects_dc_c)
  );

  // rotates move carry without touching zero, so they count as carry users
  assign carry_hit = affects_dc_c | (op == flags_pkg::OP_RLF) | (op == flags_pkg::OP_RRF);
  // owning any one arithmetic flag locks all three against the write
  assign arith_hit = affects_z | carry_hit;

  // ==========================================================
  // destination decode
  assign to_flags = exec & dest_is_file & (file_addr == flags_pkg::FLAGS_OFFSET);
  assign to_option = exec & dest_is_file & (file_addr == flags_pkg::OPTION_OFFSET);

  // result latch for the datapath write-back
  always_ff @(posedge clock) begin
    if (srst) begin
      result_r <= flags_pkg::RESULT_RESET;
    end else if (exec) begin
      result_r <= alu_result;
    end
  end

  // ==========================================================
  // flag next state: write first, ALU flags override, reset bits apart
  always_comb begin
    flags_nxt = flags_r;
    if (to_flags) begin
      // bank bits always take the written value
      flags_nxt[7:5] = alu_result[7:5];
      // arithmetic bits land only from ops that own none of them
      if (!arith_hit) begin
        flags_nxt[flags_pkg::BIT_ZERO] = alu_result[flags_pkg::BIT_ZERO];
        flags_nxt[flags_pkg::BIT_DIGIT] = alu_result[flags_pkg::BIT_DIGIT];
        flags_nxt[flags_pkg::BIT_CARRY] = alu_result[flags_pkg::BIT_CARRY];
      end
    end
    // ALU outcome wins over the write, so the written bits are blocked
    if (exec && affects_z) begin
      flags_nxt[flags_pkg::BIT_ZERO] = zero_out;
    end
    if (exec && affects_dc_c) begin
      flags_nxt[flags_pkg::BIT_DIGIT] = digit_out;
    end
    if (exec && carry_hit) begin
      flags_nxt[flags_pkg::BIT_CARRY] = carry_out;
    end
    // reset-cause bits never take a write; only events move them
    flags_nxt[flags_pkg::BIT_TOUT] = flags_r[flags_pkg::BIT_TOUT];
    flags_nxt[flags_pkg::BIT_PDOWN] = flags_r[flags_pkg::BIT_PDOWN];
    if (watchdog_timeout) begin
      flags_nxt[flags_pkg::BIT_TOUT] = 1'b0;
    end else if (watchdog_clear_instr) begin
      flags_nxt[flags_pkg::BIT_TOUT] = 1'b1;
      flags_nxt[flags_pkg::BIT_PDOWN] = 1'b1;
    end else if (sleep_instr) begin
      flags_nxt[flags_pkg::BIT_TOUT] = 1'b1;
      flags_nxt[flags_pkg::BIT_PDOWN] = 1'b0;
    end
  end

  // power-up sets both reset-cause bits
  always_ff @(posedge clock) begin
    if (srst) begin
      flags_r <= flags_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // bank select; upper bank bits are unused so only bank 0 or 1
  assign direct_addr = {1'b0, flags_r[flags_pkg::BIT_BANK_LOW], file_addr};

  // ==========================================================
  // option register
  option_ctrl u_option (
    .clock(clock),
    .srst(srst),
    .wr_en(to_option),
    .wr_data(alu_result),
    .option_r(option_rd),
    .timer_zero_ratio_log2(timer_zero_ratio_log2),
    .watchdog_timer_ratio_log2(watchdog_timer_ratio_log2),
    .portb_pullup_en(portb_pullup_en),
    .ext_int_rising(ext_int_rising),
    .timer_zero_ext_clk(timer_zero_ext_clk),
    .timer_zero_falling(timer_zero_falling)
  );
endmodule : alu_status_and_option_flags
`default_nettype wire

// >>> sim/flags_chk_props.sv
/*
  Checker for the flag and option block, bound to its top module.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module flags_chk (
  input wire logic clock,
  input wire logic srst,
  input wire flags_pkg::alu_op_type op,
  input wire logic [7:0] work_reg,
  input wire logic [7:0] file_operand,
  input wire logic [6:0] file_addr,
  input wire logic dest_is_file,
  input wire logic exec,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  input wire logic [7:0] result_r,
  input wire logic [7:0] flags_r,
  input wire logic [7:0] option_rd,
  input wire logic [8:0] direct_addr,
  input wire logic portb_pullup_en,
  input wire logic ext_int_rising
);
  // ==========================================
  // reference sums; nine bits keep the carry
  logic [8:0] add_sum;
  logic [8:0] sub_sum;
  logic [4:0] add_nib;
  logic [4:0] sub_nib;
  logic quiet;
  logic alu_src;
  assign add_sum = {1'b0, work_reg} + {1'b0, file_operand};
  assign sub_sum = {1'b0, file_operand} + {1'b0, ~work_reg} + 9'h001;
  assign add_nib = {1'b0, work_reg[3:0]} + {1'b0, file_operand[3:0]};
  assign sub_nib = {1'b0, file_operand[3:0]} + {1'b0, ~work_reg[3:0]} + 5'h01;
  assign quiet = !watchdog_clear_instr && !sleep_instr && !watchdog_timeout;
  // the flag register replaces the operand at its own offset, so skip it
  assign alu_src = exec && file_addr != flags_pkg::FLAGS_OFFSET;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence flags_clear_s;
    exec && op == flags_pkg::OP_CLR && dest_is_file && file_addr == flags_pkg::FLAGS_OFFSET && quiet;
  endsequence
  // logic ops own zero only, yet a write of them to the flags must spare digit and carry
  sequence flags_logic_wr_s;
    exec && dest_is_file && file_addr == flags_pkg::FLAGS_OFFSET &&
      op inside {flags_pkg::OP_AND, flags_pkg::OP_IOR, flags_pkg::OP_XOR};
  endsequence
  wr_block_a: assert property (flags_logic_wr_s |=> flags_r[1:0] == $past(flags_r[1:0]))
    else $error("arithmetic flag write not blocked");
  bank_addr_a: assert property (direct_addr == {1'b0, flags_r[5], file_addr})
    else $error("direct address wrong");
  add_flags_a: assert property (alu_src && op == flags_pkg::OP_ADD |=>
    result_r == $past(add_sum[7:0]) && flags_r[1:0] == {$past(add_nib[4]), $past(add_sum[8])})
    else $error("add outcome wrong");
  sub_flags_a: assert property (alu_src && op == flags_pkg::OP_SUB |=>
    result_r == $past(sub_sum[7:0]) && flags_r[1:0] == {$past(sub_nib[4]), $past(sub_sum[8])})
    else $error("subtract outcome wrong");
  zero_flag_a: assert property (alu_src && op == flags_pkg::OP_ADD |=> flags_r[2] == (result_r == 8'h00))
    else $error("zero flag wrong");
  clear_flags_a: assert property (flags_clear_s |=>
    flags_r == {3'b000, $past(flags_r[4:3]), 1'b1, $past(flags_r[1:0])})
    else $error("clear of flags wrong");
  reset_bits_a: assert property (quiet |=> $stable(flags_r[4:3]))
    else $error("reset cause bits moved");
  timeout_clr_a: assert property (watchdog_timeout |=> !flags_r[4])
    else $error("timeout flag not cleared");
  sleep_set_a: assert property (sleep_instr && !watchdog_timeout && !watchdog_clear_instr |=>
    flags_r[4:3] == 2'b10)
    else $error("sleep flags wrong");
  wdog_clear_a: assert property (watchdog_clear_instr && !watchdog_timeout |=> flags_r[4:3] == 2'b11)
    else $error("watchdog clear flags wrong");
  option_wr_a: assert property (exec && dest_is_file && file_addr == flags_pkg::OPTION_OFFSET |=>
    option_rd == result_r)
    else $error("option write lost");
  option_dec_a: assert property (portb_pullup_en == !option_rd[7] && ext_int_rising == option_rd[6])
    else $error("option decode wrong");
endmodule : flags_chk
`default_nettype wire

// >>> sim/tb.sv
/*
  Self-checking bench for the flag and option block.
  Assumes package, design and checker files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock, srst, exec, dest_is_file, watchdog_clear_instr, sleep_instr, watchdog_timeout;
  flags_pkg::alu_op_type op;
  logic [7:0] work_reg, file_operand, result_r, flags_r, option_rd, f;
  logic [7:0] timer_zero_ratio_log2, watchdog_timer_ratio_log2;
  logic [2:0] bit_sel;
  logic [6:0] file_addr;
  logic [8:0] direct_addr;
  logic portb_pullup_en, ext_int_rising, timer_zero_ext_clk, timer_zero_falling;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  alu_status_and_option_flags u_dut (.clock, .srst, .op, .work_reg, .file_operand, .bit_sel,
    .file_addr, .dest_is_file, .exec, .watchdog_clear_instr, .sleep_instr, .watchdog_timeout,
    .result_r, .flags_r, .option_rd, .direct_addr, .timer_zero_ratio_log2,
    .watchdog_timer_ratio_log2, .portb_pullup_en, .ext_int_rising, .timer_zero_ext_clk,
    .timer_zero_falling);
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // hang guard, far above the fewer than 100 cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end
  // ==========================================
  // tasks
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check8
  // one instruction: exec high for exactly one rising edge
  task automatic run(input flags_pkg::alu_op_type o, input logic [7:0] w, input logic [7:0] fo,
                     input logic [6:0] a, input logic d, input logic [2:0] b);
    @(negedge clock);
    op = o;
    work_reg = w;
    file_operand = fo;
    file_addr = a;
    dest_is_file = d;
    bit_sel = b;
    exec = 1'b1;
    @(negedge clock);
    exec = 1'b0;
  endtask : run
  task automatic alu(input flags_pkg::alu_op_type o, input logic [7:0] w, input logic [7:0] fo,
                     input logic [7:0] er, input logic [2:0] ez);
    run(o, w, fo, 7'h20, 1'b0, 3'h0);
    check8(result_r, er, "alu result");
    check8({5'h00, flags_r[2:0]}, {5'h00, ez}, "alu flags");
  endtask : alu
  // event order in e: timeout, watchdog clear, sleep
  task automatic pulse(input logic [2:0] e, input logic [1:0] ex);
    @(negedge clock);
    {watchdog_timeout, watchdog_clear_instr, sleep_instr} = e;
    @(negedge clock);
    {watchdog_timeout, watchdog_clear_instr, sleep_instr} = 3'b000;
    check8({6'h00, flags_r[4:3]}, {6'h00, ex}, "reset cause bits");
  endtask : pulse
  task automatic opt(input logic [7:0] v, input logic [3:0] dec, input logic [7:0] tz,
                     input logic [7:0] wd);
    run(flags_pkg::OP_IOR, v, 8'h00, 7'h01, 1'b1, 3'h0);
    check8(option_rd, v, "option value");
    check8({4'h0, portb_pullup_en, ext_int_rising, timer_zero_ext_clk, timer_zero_falling},
           {4'h0, dec}, "option decode");
    check8(timer_zero_ratio_log2, tz, "timer ratio");
    check8(watchdog_timer_ratio_log2, wd, "watchdog ratio");
  endtask : opt
  task automatic wrap_up();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // ==========================================
  // main sequence
  initial begin
    {srst, exec, dest_is_file, watchdog_clear_instr, sleep_instr, watchdog_timeout} = 6'h20;
    op = flags_pkg::OP_PASS;
    {work_reg, file_operand, bit_sel, file_addr} = 26'h0000020;
    repeat (16) @(negedge clock);
    srst = 1'b0;
    check8(flags_r, 8'h18, "flags reset");
    check8(result_r, 8'h00, "result reset");
    opt(8'hFF, 4'b0111, 8'h00, 8'h07);
    $display("test reset done");
    alu(flags_pkg::OP_ADD, 8'h0F, 8'h01, 8'h10, 3'b010);
    alu(flags_pkg::OP_ADD, 8'hFF, 8'h01, 8'h00, 3'b111);
    alu(flags_pkg::OP_ADD, 8'h12, 8'h34, 8'h46, 3'b000);
    alu(flags_pkg::OP_SUB, 8'h03, 8'h05, 8'h02, 3'b011);
    alu(flags_pkg::OP_SUB, 8'h05, 8'h03, 8'hFE, 3'b000);
    alu(flags_pkg::OP_SUB, 8'h07, 8'h07, 8'h00, 3'b111);
    alu(flags_pkg::OP_SUB, 8'h01, 8'h10, 8'h0F, 3'b001);
    alu(flags_pkg::OP_RLF, 8'h00, 8'h80, 8'h01, 3'b001);
    alu(flags_pkg::OP_RRF, 8'h00, 8'h00, 8'h80, 3'b000);
    alu(flags_pkg::OP_RLF, 8'h00, 8'h00, 8'h00, 3'b000);
    alu(flags_pkg::OP_SWAP, 8'h00, 8'hA5, 8'h5A, 3'b000);
    alu(flags_pkg::OP_COM, 8'h00, 8'hFF, 8'h00, 3'b100);
    alu(flags_pkg::OP_PASS, 8'h00, 8'h12, 8'h12, 3'b100);
    alu(flags_pkg::OP_INC, 8'h00, 8'h7F, 8'h80, 3'b000);
    alu(flags_pkg::OP_DEC, 8'h00, 8'h01, 8'h00, 3'b100);
    alu(flags_pkg::OP_AND, 8'h0F, 8'hF0, 8'h00, 3'b100);
    $display("test arithmetic done");
    f = flags_r;
    run(flags_pkg::OP_BSET, 8'h00, 8'h00, 7'h03, 1'b1, 3'h5);
    check8(flags_r, f | 8'h20, "bank bit set");
    check8(direct_addr[7:0], 8'h83, "direct address bank one");
    f = flags_r;
    run(flags_pkg::OP_BCLR, 8'h00, 8'h00, 7'h03, 1'b1, 3'h2);
    check8(flags_r, f & 8'hFB, "zero cleared by bit op");
    f = flags_r;
    // xor flips bits 5:3 and 0; bank bit lands, zero from the alu, carry write blocked
    run(flags_pkg::OP_XOR, 8'h39, 8'h00, 7'h03, 1'b1, 3'h0);
    check8(flags_r, {f[7:6], ~f[5], f[4:3], 1'b0, f[1:0]}, "xor to flags");
    check8(direct_addr[7:0], 8'h03, "direct address bank zero");
    run(flags_pkg::OP_BSET, 8'h00, 8'h00, 7'h03, 1'b1, 3'h5);
    // a set carry shows whether the clear leaves it alone
    run(flags_pkg::OP_BSET, 8'h00, 8'h00, 7'h03, 1'b1, 3'h0);
    f = flags_r;
    run(flags_pkg::OP_CLR, 8'h00, 8'h00, 7'h03, 1'b1, 3'h0);
    check8(flags_r, {3'b000, f[4:3], 1'b1, f[1:0]}, "clear of flags");
    $display("test flag writes done");
    pulse(3'b100, 2'b01);
    pulse(3'b001, 2'b10);
    pulse(3'b010, 2'b11);
    pulse(3'b101, 2'b01);
    $display("test reset causes done");
    opt(8'h00, 4'b1000, 8'h01, 8'h00);
    opt(8'h0A, 4'b1000, 8'h00, 8'h02);
    opt(8'h55, 4'b1101, 8'h06, 8'h00);
    $display("test option done");
    wrap_up();
  end
endmodule : tb
bind alu_status_and_option_flags flags_chk u_chk (.clock, .srst, .op, .work_reg, .file_operand,
  .file_addr, .dest_is_file, .exec, .watchdog_clear_instr, .sleep_instr, .watchdog_timeout,
  .result_r, .flags_r, .option_rd, .direct_addr, .portb_pullup_en, .ext_int_rising);
`default_nettype wire
